// ==== iop_pin_ctrl.sv ====
// Purpose: Register file and pin logic for port 2 and port 5.
// Assumes: Pin inputs are synchronous to i_clock.
// Notes: Pin drive and enable are held in flops so sleep modes retain them.
`timescale 1ns/1ps
module iop_pin_ctrl (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [iop_pkg::ADDR_W-1:0] i_addr,
  input wire logic [iop_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [iop_pkg::DATA_W-1:0] o_rdata,
  input wire iop_pkg::iop_pwr_t i_pwr_mode,
  input wire logic i_clock_source_bit3,
  input wire logic i_conv_trigger_enable,
  input wire logic i_serial_clk_out,
  output logic o_serial_data_in,
  output logic o_serial_clk_in,
  output logic o_ext_int4_n,
  output logic o_conv_ext_trigger_n,
  input wire logic [7:0] i_p2_in,
  output logic [7:0] o_p2_out,
  output logic [7:0] o_p2_oe,
  output logic [7:0] o_p2_pullup,
  input wire logic [7:0] i_p5_in,
  output logic [7:0] o_p5_out,
  output logic [7:0] o_p5_oe,
  output logic [7:0] o_p5_pullup,
  output logic [7:0] o_wakeup_n
);
  import iop_pkg::*;

  // Power mode decode, shared by both ports.
  function automatic logic is_live(input iop_pwr_t m);
    is_live = (m == PWR_ACTIVE) || (m == PWR_SUBACTIVE);
  endfunction

  function automatic logic is_off(input iop_pwr_t m);
    is_off = (m == PWR_STANDBY);
  endfunction

  logic [7:0] port2_mode_reg;
  logic [7:0] port2_direction_reg;
  logic [7:0] port2_pullup_reg;
  logic [7:0] port2_data;
  logic [7:0] port5_pin_mode;
  logic [7:0] port5_pullup_ctrl;
  logic [7:0] port5_data;
  logic [7:0] port5_direction;

  wire sel_p5_mode = (i_addr == OFS_P5_MODE);
  wire sel_p5_pull = (i_addr == OFS_P5_PULL);
  wire sel_p5_data = (i_addr == OFS_P5_DATA);
  wire sel_p5_dir = (i_addr == OFS_P5_DIR);
  wire sel_p2_mode = (i_addr == OFS_P2_MODE);
  wire sel_p2_pull = (i_addr == OFS_P2_PULL);
  wire sel_p2_data = (i_addr == OFS_P2_DATA);
  wire sel_p2_dir = (i_addr == OFS_P2_DIR);

  wire pwr_live = is_live(i_pwr_mode);
  wire pwr_off = is_off(i_pwr_mode);

  // Register writes.
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      port2_mode_reg <= RST_REG;
      port2_direction_reg <= RST_REG;
      port2_pullup_reg <= RST_REG;
      port2_data <= RST_REG;
      port5_pin_mode <= RST_REG;
      port5_pullup_ctrl <= RST_REG;
      port5_data <= RST_REG;
      port5_direction <= RST_REG;
    end else if (i_wr) begin
      if (sel_p2_mode) begin
        port2_mode_reg <= i_wdata & P2_MODE_MASK;
      end
      if (sel_p2_dir) begin
        port2_direction_reg <= i_wdata;
      end
      if (sel_p2_pull) begin
        port2_pullup_reg <= i_wdata;
      end
      if (sel_p2_data) begin
        port2_data <= i_wdata;
      end
      if (sel_p5_mode) begin
        port5_pin_mode <= i_wdata;
      end
      if (sel_p5_dir) begin
        port5_direction <= i_wdata;
      end
      if (sel_p5_pull) begin
        port5_pullup_ctrl <= i_wdata;
      end
      if (sel_p5_data) begin
        port5_data <= i_wdata;
      end
    end
  end

  // Port 2 alternate function selects.
  wire serial_in_select = port2_mode_reg[BIT_SIN_SEL];
  wire serial_clk_select = port2_mode_reg[BIT_SCK_SEL];
  wire ext_int4_select = port2_mode_reg[BIT_INT4_SEL];

  // Port 2 drive before the power-mode stage.
  logic [7:0] p2_fn_oe;
  logic [7:0] p2_fn_out;
  always_comb begin
    p2_fn_oe = port2_direction_reg;
    p2_fn_out = port2_data;
    p2_fn_oe[PIN_INONLY] = 1'b0;
    if (serial_in_select) begin
      p2_fn_oe[PIN_SIN] = 1'b0;
    end
    if (serial_clk_select) begin
      p2_fn_oe[PIN_SCK] = ~i_clock_source_bit3;
      p2_fn_out[PIN_SCK] = i_serial_clk_out;
    end
    if (ext_int4_select) begin
      p2_fn_oe[PIN_INT4] = 1'b0;
    end
  end

  // Port 5 drive: direction counts only in GPIO mode; data pass through in every mode.
  wire [7:0] p5_fn_oe = port5_direction & ~port5_pin_mode;
  wire [7:0] p5_fn_out = port5_data;

  // Pin stage: live modes follow, standby and reset float, others hold.
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_p2_oe <= RST_REG;
      o_p2_out <= RST_REG;
      o_p5_oe <= RST_REG;
      o_p5_out <= RST_REG;
    end else if (pwr_live) begin
      o_p2_oe <= p2_fn_oe;
      o_p2_out <= p2_fn_out;
      o_p5_oe <= p5_fn_oe;
      o_p5_out <= p5_fn_out;
    end else if (pwr_off) begin
      o_p2_oe <= RST_REG;
      o_p5_oe <= RST_REG;
    end
  end

  // Pull-ups stay on in standby so the pin reads high.
  wire [7:0] p2_pull_fn = ~port2_direction_reg & port2_pullup_reg;
  wire [7:0] p5_pull_fn = ~port5_direction & port5_pullup_ctrl;
  assign o_p2_pullup = p2_pull_fn & P2_PULL_MASK;
  assign o_p5_pullup = p5_pull_fn;

  // Inputs routed to the serial, interrupt and converter units.
  assign o_serial_data_in = serial_in_select & i_p2_in[PIN_SIN];
  wire sck_in_mode = serial_clk_select & i_clock_source_bit3;
  assign o_serial_clk_in = sck_in_mode & i_p2_in[PIN_SCK];
  assign o_ext_int4_n = ~ext_int4_select | i_p2_in[PIN_INT4];
  wire trig_on = ext_int4_select & i_conv_trigger_enable;
  assign o_conv_ext_trigger_n = ~trig_on | i_p2_in[PIN_INT4];

  // Wake-up inputs are active low.
  genvar n;
  generate
    for (n = 0; n < 8; n++) begin : g_wake
      assign o_wakeup_n[n] = ~port5_pin_mode[n] | i_p5_in[n];
    end
  endgenerate

  // Read mux: outputs show the latch, inputs show the pin.
  wire [7:0] p5_read = (port5_direction & port5_data) |
    (~port5_direction & i_p5_in);
  wire [7:0] p2_read = (port2_direction_reg & port2_data) |
    (~port2_direction_reg & i_p2_in);
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = UNMAPPED_READ;
    if (sel_p5_mode) begin
      next_rdata = port5_pin_mode;
    end
    if (sel_p5_pull) begin
      next_rdata = port5_pullup_ctrl;
    end
    if (sel_p5_data) begin
      next_rdata = p5_read;
    end
    if (sel_p5_dir) begin
      next_rdata = DIR_READ;
    end
    if (sel_p2_mode) begin
      next_rdata = port2_mode_reg;
    end
    if (sel_p2_pull) begin
      next_rdata = port2_pullup_reg;
    end
    if (sel_p2_data) begin
      next_rdata = p2_read;
    end
    if (sel_p2_dir) begin
      next_rdata = DIR_READ;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_rdata <= UNMAPPED_READ;
    end else if (i_rd) begin
      o_rdata <= next_rdata;
    end else begin
      o_rdata <= UNMAPPED_READ;
    end
  end

  // Checks.
  AST_P2_PIN7_FLOAT: assert property (
    @(posedge i_clock) disable iff (i_reset)
    o_p2_oe[PIN_INONLY] == 1'b0)
    else $error("Port 2 pin 7 is driven.");

  AST_P2_PIN7_NO_PULL: assert property (
    @(posedge i_clock) disable iff (i_reset)
    o_p2_pullup[PIN_INONLY] == 1'b0)
    else $error("Port 2 pin 7 pull-up is on.");

  AST_P2_PULL_RULE: assert property (
    @(posedge i_clock) disable iff (i_reset)
    o_p2_pullup[6:0] ==
      (port2_pullup_reg[6:0] & ~port2_direction_reg[6:0]))
    else $error("Port 2 pull-up wrong.");

  AST_P5_PULL_RULE: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (port5_direction == 8'h00) |-> o_p5_pullup == port5_pullup_ctrl)
    else $error("Port 5 pull-up wrong.");

  AST_DIR_READ_ONES: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (i_rd && sel_p5_dir) |=> o_rdata == 8'hff)
    else $error("Direction read is not all ones.");

  AST_P5_DATA_READ: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (i_rd && sel_p5_data && !i_wr) |=> o_rdata ==
      (($past(port5_direction) & $past(port5_data)) |
       (~$past(port5_direction) & $past(i_p5_in))))
    else $error("Port 5 data read wrong.");

  AST_STANDBY_FLOAT: assert property (
    @(posedge i_clock) disable iff (i_reset)
    pwr_off |=> (o_p2_oe == 8'h00) && (o_p5_oe == 8'h00))
    else $error("Pins driven in standby.");

  AST_SLEEP_HOLD: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (!pwr_live && !pwr_off) |=> $stable(o_p5_oe) && $stable(o_p5_out)
      && $stable(o_p2_oe) && $stable(o_p2_out))
    else $error("Pins changed while held.");

  AST_P5_GPIO_ONLY: assert property (
    @(posedge i_clock) disable iff (i_reset)
    pwr_live |=> o_p5_oe == ($past(port5_direction) &
      ~$past(port5_pin_mode)))
    else $error("Port 5 drive ignores mode.");

  AST_SIN_INPUT: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (pwr_live && serial_in_select) |=> !o_p2_oe[PIN_SIN])
    else $error("Serial input pin driven.");

  AST_SCK_DIR: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (pwr_live && serial_clk_select) |=>
      o_p2_oe[PIN_SCK] == !$past(i_clock_source_bit3))
    else $error("Serial clock pin direction wrong.");

  AST_INT4_TRIG: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (!ext_int4_select || !i_conv_trigger_enable) |->
      o_conv_ext_trigger_n)
    else $error("Trigger passed while disabled.");

  AST_WAKE_GATE: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (port5_pin_mode == 8'h00) |-> o_wakeup_n == 8'hff)
    else $error("Wake-up asserted in GPIO mode.");

  AST_RESET_CLEAR: assert property (
    @(posedge i_clock)
    i_reset |=> port5_data == 8'h00 && port5_direction == 8'h00 &&
      port5_pullup_ctrl == 8'h00 && o_p2_pullup == 8'h00)
    else $error("Reset values wrong.");

  AST_RESET_FLOAT: assert property (
    @(posedge i_clock)
    i_reset |=> (o_p2_oe == 8'h00) && (o_p5_oe == 8'h00))
    else $error("Pins driven after reset.");

  AST_INT4_INPUT: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (pwr_live && ext_int4_select) |=> !o_p2_oe[PIN_INT4])
    else $error("Interrupt 4 pin driven.");

  AST_INT4_PATH: assert property (
    @(posedge i_clock) disable iff (i_reset)
    ext_int4_select |-> o_ext_int4_n == i_p2_in[PIN_INT4])
    else $error("Interrupt 4 input does not follow the pin.");

  AST_TRIG_PATH: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (ext_int4_select && i_conv_trigger_enable) |->
      o_conv_ext_trigger_n == i_p2_in[PIN_INT4])
    else $error("Trigger input does not follow the pin.");

  AST_SIN_PATH: assert property (
    @(posedge i_clock) disable iff (i_reset)
    serial_in_select |-> o_serial_data_in == i_p2_in[PIN_SIN])
    else $error("Serial data input does not follow the pin.");

  AST_SIN_GPIO: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (pwr_live && !serial_in_select) |=>
      o_p2_oe[PIN_SIN] == $past(port2_direction_reg[PIN_SIN]))
    else $error("Pin 2 ignores its direction bit.");

  AST_SCK_IN_GATE: assert property (
    @(posedge i_clock) disable iff (i_reset)
    !(serial_clk_select && i_clock_source_bit3) |-> !o_serial_clk_in)
    else $error("Serial clock input passed while not selected.");

  AST_SCK_OUT_DATA: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (pwr_live && serial_clk_select) |=>
      o_p2_out[PIN_SCK] == $past(i_serial_clk_out))
    else $error("Serial clock output does not follow the serial unit.");

  AST_P2_PULL_OUT_OFF: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (o_p2_pullup & port2_direction_reg) == 8'h00)
    else $error("Port 2 pull-up on an output pin.");

  AST_P5_PULL_OUT_OFF: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (o_p5_pullup & port5_direction) == 8'h00)
    else $error("Port 5 pull-up on an output pin.");

  AST_STANDBY_PULL: assert property (
    @(posedge i_clock) disable iff (i_reset)
    pwr_off |-> o_p5_pullup == (port5_pullup_ctrl & ~port5_direction))
    else $error("Port 5 pull-up dropped in standby.");

  AST_P5_DRIVE_DATA: assert property (
    @(posedge i_clock) disable iff (i_reset)
    pwr_live |=> o_p5_out == $past(port5_data))
    else $error("Port 5 drive does not follow the latch.");

  AST_WAKE_PATH: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (port5_pin_mode != 8'h00) |->
      ((o_wakeup_n ^ i_p5_in) & port5_pin_mode) == 8'h00)
    else $error("Wake-up inputs do not follow the pins.");

endmodule // iop_pin_ctrl

// ==== iop_pkg.sv ====
// Purpose: Shared constants for the port 2 and port 5 pin control block.
// Assumes: Byte-wide registers on a 16-bit address bus.
// Notes: Port 2 offsets and select bit positions are local choices.
package iop_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [15:0] OFS_P5_MODE = 16'hff9b;
  localparam logic [15:0] OFS_P5_PULL = 16'hff9e;
  localparam logic [15:0] OFS_P5_DATA = 16'hffd8;
  localparam logic [15:0] OFS_P5_DIR = 16'hffe8;
  localparam logic [15:0] OFS_P2_MODE = 16'hffc9;
  localparam logic [15:0] OFS_P2_PULL = 16'hff9d;
  localparam logic [15:0] OFS_P2_DATA = 16'hffd5;
  localparam logic [15:0] OFS_P2_DIR = 16'hffe5;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] DIR_READ = 8'hff;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam int BIT_INT4_SEL = 0;
  localparam int BIT_SCK_SEL = 1;
  localparam int BIT_SIN_SEL = 2;
  localparam int PIN_INT4 = 0;
  localparam int PIN_SCK = 1;
  localparam int PIN_SIN = 2;
  localparam int PIN_INONLY = 7;
  localparam logic [7:0] P2_MODE_MASK = 8'h07;
  localparam logic [7:0] P2_PULL_MASK = 8'h7f;
  typedef enum logic [5:0] {
    PWR_ACTIVE = 6'b00_0001,
    PWR_SUBACTIVE = 6'b00_0010,
    PWR_SLEEP = 6'b00_0100,
    PWR_SUBSLEEP = 6'b00_1000,
    PWR_WATCH = 6'b01_0000,
    PWR_STANDBY = 6'b10_0000
  } iop_pwr_t;
endpackage

// ==== test_io_port_pin_control.sv ====
// Purpose: Self-checking bench for the port 2 and port 5 pin control block.
// Assumes: One clock; registers are reached over the strobe bus.
// Notes: Random settings come from a fixed seed, so every run is the same.
`timescale 1ns/1ps
module test_io_port_pin_control;
  import iop_pkg::*;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_cks = 1'b0;
  logic i_trg = 1'b0;
  logic i_sck = 1'b0;
  logic [15:0] i_addr = 16'h0000;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] i_p2_in = 8'h00;
  logic [7:0] i_p5_in = 8'h00;
  iop_pwr_t i_pwr = PWR_ACTIVE;
  iop_pwr_t hold_mode [3] = '{PWR_SLEEP, PWR_SUBSLEEP, PWR_WATCH};
  logic o_sdi, o_sci, o_int_n, o_trg_n;
  logic [7:0] o_rdata, o_p2_out, o_p2_oe, o_p2_pullup;
  logic [7:0] o_p5_out, o_p5_oe, o_p5_pullup, o_wakeup_n;
  logic [7:0] d, v, p, m, e;
  int err_total = 0;
  int check_count = 0;
  int seed = 32;

  iop_pin_ctrl i_iop_pin_ctrl (
    .i_clock(i_clock), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pwr_mode(i_pwr),
    .i_clock_source_bit3(i_cks), .i_conv_trigger_enable(i_trg),
    .i_serial_clk_out(i_sck), .o_serial_data_in(o_sdi), .o_serial_clk_in(o_sci),
    .o_ext_int4_n(o_int_n), .o_conv_ext_trigger_n(o_trg_n), .i_p2_in(i_p2_in),
    .o_p2_out(o_p2_out), .o_p2_oe(o_p2_oe), .o_p2_pullup(o_p2_pullup),
    .i_p5_in(i_p5_in), .o_p5_out(o_p5_out), .o_p5_oe(o_p5_oe),
    .o_p5_pullup(o_p5_pullup), .o_wakeup_n(o_wakeup_n)
  );

  always #2.5 i_clock = ~i_clock;

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] x);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= x;
    @(posedge i_clock);
    i_wr <= 1'b0;
    @(posedge i_clock);
  endtask

  // Read data stand only in the cycle after the strobe, and are zero after it.
  task automatic rdr(input logic [15:0] a, input logic [7:0] exp, input string name);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    chk(name, exp, o_rdata);
    @(posedge i_clock);
    #1;
    chk("rdata_idle", 8'h00, o_rdata);
  endtask

  task automatic settle;
    repeat (2) @(posedge i_clock);
    #1;
  endtask

  // Port 2 pins that the block drives, after the alternate functions take over.
  function automatic logic [7:0] p2_oe(input logic [7:0] dd, input logic [7:0] mm,
                                       input logic c);
    logic [7:0] r;
    r = dd & 8'h7f;
    if (mm[0]) r[0] = 1'b0;
    if (mm[2]) r[2] = 1'b0;
    if (mm[1]) r[1] = ~c;
    return r;
  endfunction

  initial begin
    repeat (20000) @(posedge i_clock);
    err_total++;
    test_done;
  end

  initial begin
    repeat (2) @(posedge i_clock);
    i_reset <= 1'b0;
    i_p5_in <= 8'ha5;
    @(posedge i_clock);
    #1;
    chk("p5_oe", 8'h00, o_p5_oe);
    chk("p2_oe", 8'h00, o_p2_oe);
    chk("p5_pullup", 8'h00, o_p5_pullup);
    chk("p2_pullup", 8'h00, o_p2_pullup);
    rdr(OFS_P5_DIR, 8'hff, "p5_dir");
    rdr(OFS_P5_PULL, 8'h00, "p5_pull");
    rdr(OFS_P5_MODE, 8'h00, "p5_mode");
    rdr(OFS_P5_DATA, 8'ha5, "p5_data_pin");
    wr(OFS_P5_DIR, 8'hff);
    rdr(OFS_P5_DATA, 8'h00, "p5_data");
    rdr(16'h1234, UNMAPPED_READ, "unmapped");
    wr(OFS_P2_PULL, 8'hff);
    settle;
    chk("p2_pullup", 8'h7f, o_p2_pullup);
    $display("test reset_and_readback done");
    for (int k = 0; k < 40; k++) begin
      d = 8'($random(seed));
      v = 8'($random(seed));
      p = 8'($random(seed));
      m = 8'($random(seed));
      i_p5_in <= 8'($random(seed));
      i_p2_in <= 8'($random(seed));
      i_cks <= k[0];
      i_trg <= k[1];
      i_sck <= k[2];
      i_pwr <= k[3] ? PWR_SUBACTIVE : PWR_ACTIVE;
      wr(OFS_P5_DIR, d);
      wr(OFS_P5_DATA, v);
      wr(OFS_P5_PULL, p);
      wr(OFS_P5_MODE, m);
      wr(OFS_P2_DIR, d);
      wr(OFS_P2_DATA, v);
      wr(OFS_P2_PULL, p);
      wr(OFS_P2_MODE, m);
      settle;
      chk("p5_oe", d & ~m, o_p5_oe);
      chk("p5_out", v & d & ~m, o_p5_out & d & ~m);
      chk("p5_pullup", p & ~d, o_p5_pullup);
      chk("wakeup_n", i_p5_in | ~m, o_wakeup_n);
      rdr(OFS_P5_DATA, (v & d) | (i_p5_in & ~d), "p5_data");
      e = p2_oe(d, m, i_cks);
      chk("p2_oe", e, o_p2_oe);
      chk("p2_out", {v[7:2], m[1] ? i_sck : v[1], v[0]} & e, o_p2_out & e);
      chk("p2_pullup", p & ~d & 8'h7f, o_p2_pullup);
      chk("p2_func", {4'h0, m[2] ? i_p2_in[2] : 1'b0, (m[1] & i_cks) ? i_p2_in[1] : 1'b0,
          m[0] ? i_p2_in[0] : 1'b1, (m[0] & i_trg) ? i_p2_in[0] : 1'b1},
          {4'h0, o_sdi, o_sci, o_int_n, o_trg_n});
    end
    $display("test random_config done");
    i_pwr <= PWR_ACTIVE;
    wr(OFS_P5_MODE, 8'h00);
    wr(OFS_P5_DIR, 8'h0f);
    wr(OFS_P5_PULL, 8'hf0);
    settle;
    for (int k = 0; k < 3; k++) begin
      @(posedge i_clock);
      i_pwr <= hold_mode[k];
      wr(OFS_P5_DIR, 8'hf0);
      settle;
      chk("p5_oe_hold", 8'h0f, o_p5_oe);
      wr(OFS_P5_DIR, 8'h0f);
    end
    @(posedge i_clock);
    i_pwr <= PWR_STANDBY;
    settle;
    chk("p5_oe_standby", 8'h00, o_p5_oe);
    chk("p5_pullup_standby", 8'hf0, o_p5_pullup);
    @(posedge i_clock);
    i_pwr <= PWR_ACTIVE;
    settle;
    chk("p5_oe_active", 8'h0f, o_p5_oe);
    $display("test power_modes done");
    test_done;
  end
endmodule // test_io_port_pin_control
